// File: rtl/adcie_top.sv
/*
  adcie_top: interrupt enable set/clear registers, sticky event flags and the
  interrupt line of the successive-approximation converter.
  assumes event pulses arrive one cycle wide on clk_i; AHB-Lite slave, always OKAY.
*/
`timescale 1ns/100ps

// Contract
// [R1] write one to bit 0 disables started interrupt; read shows enable
// [R2] write one to bit 1 disables buffer-end interrupt; read shows enable
// [R3] write one to bit 2 disables conversion-done interrupt; read shows enable
// [R4] write one to bit 3 disables result-stored interrupt; read shows enable
// [R5] write one to bit 4 disables calibration-complete interrupt; read shows enable
// [R6] write one to bit 5 disables stopped interrupt; read shows enable
// [R7] write one to bit 6 disables channel 0 upper limit interrupt
// [R8] write one to bit 7 disables channel 0 lower limit interrupt
// [R9] bits 8 and 9 disable channel 1 upper and lower limit
// [R10] bits 10 and 11 disable channel 2 upper and lower limit
// [R11] bits 12 and 13 disable channel 3 upper and lower limit
// [R12] bits 14 and 15 disable channel 4 upper and lower limit
// [R13] bits 16 and 17 disable channel 5 upper and lower limit
// [R14] bits 18 and 19 disable channel 6 upper and lower limit
// [R15] zero bits leave enables alone; set and clear read the same state
module adcie_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // converter events, one-cycle pulses
  input wire adcie_pkg::adcie_evt_t evt_i,
  // enable state and interrupt
  output adcie_pkg::adcie_evt_t int_en_o,
  output logic irq_o
);

  // ************************************************************
  // bus front end
  // ************************************************************
  adcie_pkg::adcie_req_t req;
  logic accept;

  adcie_ahb_front u_front (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hready_i(hready_i),
    .req_o(req),
    .accept_o(accept)
  );

  // ************************************************************
  // write decode
  // ************************************************************
  function automatic logic hit(input adcie_pkg::adcie_req_t r, input logic [11:0] ofs);
    hit = r.vld && r.wr && (r.addr == ofs);
  endfunction

  // pads an enable or pending vector to a bus word, unused bits read zero
  function automatic logic [31:0] widen(input adcie_pkg::adcie_evt_t v);
    widen = {{(32-adcie_pkg::NUM_EVT){1'b0}}, v};
  endfunction

  logic wr_set;
  logic wr_clr;
  logic wr_pend;
  adcie_pkg::adcie_evt_t wmask;

  assign wr_set = hit(req, adcie_pkg::INT_EN_SET_OFS);
  assign wr_clr = hit(req, adcie_pkg::INT_EN_CLR_OFS);
  assign wr_pend = hit(req, adcie_pkg::EVT_PEND_OFS);
  // write lands in the data phase, so the mask comes straight off hwdata
  assign wmask = hwdata_i[adcie_pkg::NUM_EVT-1:0];

  // ************************************************************
  // shared enable state
  // ************************************************************
  adcie_pkg::adcie_evt_t en_q;
  adcie_pkg::adcie_evt_t en_d;

  always_comb begin
    en_d = en_q;
    if (wr_set) begin
      en_d = en_q | wmask; // R15
    end
    if (wr_clr) begin
      // each one bit drops its own enable, zero bits keep theirs
      en_d = en_q & ~wmask; // R1 R2 R3 R4 R5 R6 R7 R8 R9 R10 R11 R12 R13 R14 R15
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      en_q <= adcie_pkg::REG_RESET[adcie_pkg::NUM_EVT-1:0];
    end else begin
      en_q <= en_d;
    end
  end

  // ************************************************************
  // sticky event flags, set beats write-one clear
  // ************************************************************
  adcie_pkg::adcie_evt_t pend_q;
  adcie_pkg::adcie_evt_t pend_d;

  always_comb begin
    pend_d = pend_q;
    if (wr_pend) begin
      pend_d = pend_q & ~wmask;
    end
    pend_d = pend_d | evt_i;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pend_q <= adcie_pkg::REG_RESET[adcie_pkg::NUM_EVT-1:0];
    end else begin
      pend_q <= pend_d;
    end
  end

  // ************************************************************
  // interrupt line and enable output
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
      int_en_o <= '0;
    end else begin
      irq_o <= |(pend_d & en_d);
      int_en_o <= en_d;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  // read data built from next-state values so a read right after a write
  // already sees the written value
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = adcie_pkg::UNMAPPED_RDATA;
    unique case (haddr_i[adcie_pkg::ADDR_W-1:0])
      adcie_pkg::INT_EN_SET_OFS: begin
        rd_mux = widen(en_d);
      end
      adcie_pkg::INT_EN_CLR_OFS: begin
        rd_mux = widen(en_d); // R15
      end
      adcie_pkg::EVT_PEND_OFS: begin
        rd_mux = widen(pend_d);
      end
      default: begin
        rd_mux = adcie_pkg::UNMAPPED_RDATA;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hrdata_o <= '0;
      hreadyout_o <= 1'b1;
      hresp_o <= adcie_pkg::HRESP_OKAY;
    end else begin
      if (accept && !hwrite_i) begin
        hrdata_o <= rd_mux; // R1 R2 R3 R4 R5 R6
      end
      hreadyout_o <= 1'b1;
      hresp_o <= adcie_pkg::HRESP_OKAY;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_clr(int b);
    wr_clr && wmask[b] && !wr_set |=> !en_q[b] && !int_en_o[b];
  endproperty

  // each field of a channel pair is dropped by its own one bit
  property p_pair(int n);
    wr_clr |=> (en_q[adcie_pkg::CHAN_LIMIT_BASE_BIT + 2*n +: 2]
      & $past(wmask[adcie_pkg::CHAN_LIMIT_BASE_BIT + 2*n +: 2])) == 2'h0;
  endproperty

  a_clr_started: assert property (p_clr(0)) else $error("started enable not cleared"); // R1
  a_clr_buf_end: assert property (p_clr(1)) else $error("buffer-end enable not cleared"); // R2
  a_clr_conv_done: assert property (p_clr(2)) else $error("done enable not cleared"); // R3
  a_clr_result: assert property (p_clr(3)) else $error("result enable not cleared"); // R4
  a_clr_calib: assert property (p_clr(4)) else $error("calibration enable not cleared"); // R5
  a_clr_stopped: assert property (p_clr(5)) else $error("stopped enable not cleared"); // R6
  a_clr_ch0_upper: assert property (p_clr(6)) else $error("ch0 upper not cleared"); // R7
  a_clr_ch0_lower: assert property (p_clr(7)) else $error("ch0 lower not cleared"); // R8

  a_clr_ch1_upper: assert property (p_clr(8)) else $error("ch1 upper not cleared"); // R9
  a_clr_ch1_lower: assert property (p_clr(9)) else $error("ch1 lower not cleared"); // R9
  a_clr_ch2_upper: assert property (p_clr(10)) else $error("ch2 upper not cleared"); // R10
  a_clr_ch2_lower: assert property (p_clr(11)) else $error("ch2 lower not cleared"); // R10
  a_clr_ch3_upper: assert property (p_clr(12)) else $error("ch3 upper not cleared"); // R11
  a_clr_ch3_lower: assert property (p_clr(13)) else $error("ch3 lower not cleared"); // R11
  a_clr_ch4_upper: assert property (p_clr(14)) else $error("ch4 upper not cleared"); // R12
  a_clr_ch4_lower: assert property (p_clr(15)) else $error("ch4 lower not cleared"); // R12
  a_clr_ch5_upper: assert property (p_clr(16)) else $error("ch5 upper not cleared"); // R13
  a_clr_ch5_lower: assert property (p_clr(17)) else $error("ch5 lower not cleared"); // R13
  a_clr_ch6_upper: assert property (p_clr(18)) else $error("ch6 upper not cleared"); // R14
  a_clr_ch6_lower: assert property (p_clr(19)) else $error("ch6 lower not cleared"); // R14

  a_clr_ch1_pair: assert property (p_pair(1)) // R9
    else $error("ch1 limit enables not cleared");
  a_clr_ch2_pair: assert property (p_pair(2)) // R10
    else $error("ch2 limit enables not cleared");
  a_clr_ch3_pair: assert property (p_pair(3)) // R11
    else $error("ch3 limit enables not cleared");
  a_clr_ch4_pair: assert property (p_pair(4)) // R12
    else $error("ch4 limit enables not cleared");
  a_clr_ch5_pair: assert property (p_pair(5)) // R13
    else $error("ch5 limit enables not cleared");
  a_clr_ch6_pair: assert property (p_pair(6)) // R14
    else $error("ch6 limit enables not cleared");

  a_zero_keeps_enable: assert property (wr_clr |=> (en_q & ~$past(wmask)) == $past(en_q & ~wmask) // R15
      && (en_q & $past(~wmask)) == ($past(en_q) & $past(~wmask)))
    else $error("zero bit changed an enable");

  a_clear_readback: assert property (accept && !hwrite_i // R1 R15
      && haddr_i[11:0] == adcie_pkg::INT_EN_CLR_OFS |=> hrdata_o[19:0] == en_q
      && hrdata_o[31:20] == 12'h000)
    else $error("clear register read mismatch");

  a_no_write_hold: assert property (!wr_set && !wr_clr |=> $stable(en_q)) // R15
    else $error("enable changed without a write");

  a_irq_follows: assert property (##1 irq_o == |($past(pend_d) & $past(en_d)))
    else $error("interrupt line mismatch");

  // ************************************************************
  // bus side, pending flags and reset
  // ************************************************************

  a_set_enable: assert property (wr_set |=> (en_q & $past(wmask)) == $past(wmask)) // R15
    else $error("set write did not enable");

  a_clr_zero_mask: assert property (wr_clr && wmask == '0 |=> $stable(en_q)) // R15
    else $error("zero clear write changed enables");

  a_en_output: assert property (int_en_o == en_q) // R15
    else $error("enable output differs from enable state");

  a_set_readback: assert property (accept && !hwrite_i // R15
      && haddr_i[11:0] == adcie_pkg::INT_EN_SET_OFS |=> hrdata_o == widen(en_q))
    else $error("set register read mismatch");

  a_unmapped_read: assert property (accept && !hwrite_i
      && haddr_i[11:0] != adcie_pkg::INT_EN_SET_OFS
      && haddr_i[11:0] != adcie_pkg::INT_EN_CLR_OFS
      && haddr_i[11:0] != adcie_pkg::EVT_PEND_OFS |=> hrdata_o == adcie_pkg::UNMAPPED_RDATA)
    else $error("unmapped read not zero");

  a_hold_rdata: assert property (!(accept && !hwrite_i) |=> $stable(hrdata_o))
    else $error("read data changed without a read");

  a_pend_set_wins: assert property (evt_i != '0 |=> (pend_q & $past(evt_i)) == $past(evt_i))
    else $error("event lost its pending flag");

  a_pend_clear: assert property (wr_pend
      |=> (pend_q & $past(wmask) & ~$past(evt_i)) == '0)
    else $error("pending flag not cleared");

  a_pend_hold: assert property (evt_i == '0 && !wr_pend |=> $stable(pend_q))
    else $error("pending flags changed without cause");

  a_mask_drops_irq: assert property (wr_clr && (en_q & ~wmask) == '0 |=> !irq_o) // R1 R14
    else $error("interrupt still raised with all enables cleared");

  a_bus_okay: assert property (hreadyout_o && hresp_o == adcie_pkg::HRESP_OKAY)
    else $error("bus response not okay without wait");

  a_reset_state: assert property (disable iff (1'b0) sys_rst_i |=> en_q == '0 && pend_q == '0
      && !irq_o && int_en_o == '0 && hrdata_o == '0 && hreadyout_o)
    else $error("reset state wrong");

  c_clear_one: cover property (wr_clr && wmask != '0 ##1 en_q != $past(en_q));
  c_event_irq: cover property (evt_i != '0 ##1 irq_o);
  c_set_then_clr: cover property (wr_set ##[1:4] wr_clr);
  c_pair_clear: cover property (wr_clr && wmask[9:8] == 2'h3);
  c_irq_masked: cover property (irq_o ##1 !irq_o);

endmodule

// File: rtl/adcie_pkg.sv
/*
  adcie_pkg: constants and carrier types of the converter interrupt enable block.
  assumes a 32-bit AHB-Lite register bus, with one aligned word per register.
*/
package adcie_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] EVT_PEND_OFS = 12'h100;
  localparam logic [11:0] INT_EN_SET_OFS = 12'h304;
  localparam logic [11:0] INT_EN_CLR_OFS = 12'h308;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_RDATA = 32'h0000_0000;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int NUM_EVT = 20;
  localparam int STARTED_BIT = 0;
  localparam int BUF_END_BIT = 1;
  localparam int CONV_DONE_BIT = 2;
  localparam int RESULT_STORED_BIT = 3;
  localparam int CALIBRATION_COMPLETE_BIT = 4;
  localparam int STOPPED_BIT = 5;
  localparam int CHAN_LIMIT_BASE_BIT = 6;

  // ************************************************************
  // bus codes
  // ************************************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // ************************************************************
  // carrier types
  // ************************************************************
  typedef logic [NUM_EVT-1:0] adcie_evt_t;

  typedef struct packed {
    logic vld;
    logic wr;
    logic [ADDR_W-1:0] addr;
  } adcie_req_t;

endpackage

// File: rtl/adcie_ahb_front.sv
/*
  adcie_ahb_front: AHB-Lite address phase capture for the interrupt enable block.
  assumes a single master, zero wait states, single word transfers only.
*/
`timescale 1ns/100ps

module adcie_ahb_front (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // address phase
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  // captured request, valid during the data phase
  output adcie_pkg::adcie_req_t req_o,
  output logic accept_o
);

  adcie_pkg::adcie_req_t req_q;

  // only transfers seen with hready high are taken
  assign accept_o = hsel_i && hready_i && htrans_i[1];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      req_q <= '0;
    end else begin
      req_q.vld <= accept_o;
      req_q.wr <= accept_o && hwrite_i;
      req_q.addr <= haddr_i[adcie_pkg::ADDR_W-1:0];
    end
  end

  assign req_o = req_q;

endmodule

// File: tb/adc_interrupt_enable_clear_tb_top.sv
/*
  adc_interrupt_enable_clear_tb_top: random and directed checks of the enable clear register.
  assumes adcie_top with zero wait states and hready looped back from hreadyout.
*/
`timescale 1ns/100ps

module adc_interrupt_enable_clear_tb_top;
  localparam logic [11:0] SET = adcie_pkg::INT_EN_SET_OFS;
  localparam logic [11:0] CLR = adcie_pkg::INT_EN_CLR_OFS;
  localparam logic [11:0] PND = adcie_pkg::EVT_PEND_OFS;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  adcie_pkg::adcie_evt_t evt_i = '0;
  adcie_pkg::adcie_evt_t int_en_o;
  adcie_pkg::adcie_evt_t en;
  logic hreadyout_o;
  logic hresp_o;
  logic irq_o;
  logic [31:0] hrdata_o;
  logic [31:0] rd;
  logic [31:0] d;
  int n_errors = 0;
  int n_compared = 0;

  adcie_top u_adcie_top (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .evt_i(evt_i), .int_en_o(int_en_o), .irq_o(irq_o)
  );

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // ************************************************************
  // bus, model and compare
  // ************************************************************
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    haddr_i <= {20'h0, a};
    htrans_i <= adcie_pkg::HTRANS_NONSEQ;
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask

  function automatic adcie_pkg::adcie_evt_t upd(input logic s, input logic [31:0] wd);
    return s ? (en | wd[19:0]) : (en & ~wd[19:0]);
  endfunction

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic rdchk();
    bus(1'b0, CLR, 32'h0);
    chk("clear readback", {12'h0, en}, rd);
    chk("enable output", {12'h0, en}, {12'h0, int_en_o});
    chk("response okay", {31'h0, adcie_pkg::HRESP_OKAY}, {31'h0, hresp_o});
    bus(1'b0, SET, 32'h0);
    chk("set readback", {12'h0, en}, rd);
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #100us;
    n_errors++;
    stop_test();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    void'($urandom(14));
    en = '0;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rdchk();
    bus(1'b1, SET, 32'hffff_ffff);
    en = upd(1'b1, 32'hffff_ffff);
    bus(1'b1, CLR, 32'h0);
    rdchk();
    // one field at a time, lowest first
    for (int i = 0; i < 20; i++) begin
      bus(1'b1, CLR, 32'h1 << i);
      en = upd(1'b0, 32'h1 << i);
      rdchk();
    end
    bus(1'b1, 12'h7f0, 32'hffff_ffff);
    bus(1'b0, 12'h7f0, 32'h0);
    chk("unmapped read", 32'h0, rd);
    repeat (40) begin
      d = $urandom;
      if ($urandom % 2) begin
        bus(1'b1, SET, d);
        en = upd(1'b1, d);
      end else begin
        bus(1'b1, CLR, d);
        en = upd(1'b0, d);
      end
      rdchk();
    end
    // interrupt masked by clearing its enable
    bus(1'b1, CLR, 32'hffff_ffff);
    bus(1'b1, SET, 32'h8);
    en = 20'h8;
    @(posedge clk_i);
    evt_i <= 20'h8;
    @(posedge clk_i);
    evt_i <= '0;
    #1;
    chk("irq after event", 32'h1, {31'h0, irq_o});
    bus(1'b1, CLR, 32'h8);
    en = '0;
    #1;
    chk("irq after clear", 32'h0, {31'h0, irq_o});
    rdchk();
    bus(1'b1, SET, 32'h8);
    #1;
    chk("irq re-enabled", 32'h1, {31'h0, irq_o});
    bus(1'b0, PND, 32'h0);
    chk("pending readback", 32'h8, rd);
    bus(1'b1, PND, 32'h8);
    #1;
    chk("irq pending cleared", 32'h0, {31'h0, irq_o});
    bus(1'b0, PND, 32'h0);
    chk("pending after clear", 32'h0, rd);
    stop_test();
  end
endmodule
